// ---- hdl/pwr_mux_pkg.sv ----
// Constants for the power multiplexer control block.
// Assumes a 125 MHz system clock; long counts live as top parameters.
package pwr_mux_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PATH = 8'h01;
  localparam logic [7:0] REG_PROT = 8'h02;
  localparam logic [7:0] REG_THR = 8'h03;
  localparam logic [7:0] REG_CC = 8'h04;
  localparam logic [7:0] PATH_RST = 8'h5A;
  localparam logic [7:0] PROT_RST = 8'h62;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] CC_RST = 8'h00;
  localparam logic [4:0] DEV_ADDR_BASE = 5'h10;
  localparam int PDIS_BIT = 7;
  localparam int DIR_BIT = 2;
  localparam int SEL_BIT = 1;
  localparam int AUTO_BIT = 1;
  localparam int FORCE_BIT = 0;
  localparam int MASK_BIT = 3;
  localparam int SRST_BIT = 0;
  localparam int BYP1_BIT = 7;
  localparam int BYP2_BIT = 6;
  localparam int CAB1_BIT = 5;
  localparam int CAB2_BIT = 4;
  localparam int SWDIS_BIT = 1;
  localparam int unsigned OC_UNIT_MS = 1;
  localparam int unsigned DSG_UNIT_MS = 50;
  localparam int unsigned CC_DEGLITCH_US = 30;
  // Strictly longer than the deglitch time
  localparam int unsigned CC_DEGLITCH_CYC = CC_DEGLITCH_US * CLK_MHZ + 1;
  localparam int unsigned TRANSITION_US = 20;
  localparam int unsigned TRANSITION_CYC = TRANSITION_US * CLK_MHZ;
  localparam int unsigned OC_MULT0 = 1;
  localparam int unsigned OC_MULT1 = 10;
  localparam int unsigned OC_MULT2 = 50;
  localparam int unsigned OC_MULT3 = 100;
endpackage : pwr_mux_pkg

// ---- hdl/regbus_if.sv ----
// Byte-wide register access between the serial target and the register bank.
// Strobes are one-cycle pulses; rdata is answered combinationally.
`timescale 1ns/1ns
`default_nettype none
interface regbus_if;
  logic       wr;
  logic       rd;
  logic       stop;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport target (output wr, rd, stop, addr, wdata, input rdata);
  modport regs (input wr, rd, stop, addr, wdata, output rdata);
endinterface : regbus_if
`default_nettype wire

// ---- hdl/i2c_target.sv ----
// Two-wire serial target with a register pointer that auto-increments.
// Assumes SCL well below the system clock; pins are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module i2c_target (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [1:0] i_addr_sel,
  output logic            o_sda_oe,
  regbus_if.target        bus
);
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_DEV = 3'h1, S_REG = 3'h2, S_WR = 3'h3, S_RD = 3'h4
  } phase_t;
  phase_t     st_q;
  logic       scl_m_q, scl_s_q, scl_p_q;
  logic       sda_m_q, sda_s_q, sda_p_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic [7:0] addr_q;
  logic [7:0] wd_q;
  logic       rw_q, nack_q, wr_q, rd_q, stop_q;
  logic       rise, fall, start, stop, act;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {i_scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {i_sda, sda_m_q, sda_s_q};
    end
  end

  assign rise = scl_s_q & ~scl_p_q;
  assign fall = ~scl_s_q & scl_p_q;
  assign start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign act = st_q != S_IDLE;

  always_ff @(posedge i_mclk) begin
    if (i_rst || stop) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (start) begin
      st_q <= S_DEV;
      cnt_q <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (rd_q) begin
      sh_q <= bus.rdata;
      o_sda_oe <= ~bus.rdata[7];
    end else if (rise && act) begin
      if (cnt_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_s_q};
        cnt_q <= cnt_q + 4'h1;
      end else begin
        nack_q <= sda_s_q;
        cnt_q <= 4'h9;
      end
    end else if (fall && act && cnt_q == 4'h8) begin
      unique case (st_q)
        S_DEV: begin
          if (sh_q[7:1] == {pwr_mux_pkg::DEV_ADDR_BASE, i_addr_sel}) begin
            o_sda_oe <= 1'b1;
            rw_q <= sh_q[0];
          end else begin
            st_q <= S_IDLE;
          end
        end
        S_RD: o_sda_oe <= 1'b0;
        default: o_sda_oe <= 1'b1;
      endcase
    end else if (fall && act && cnt_q == 4'h9) begin
      cnt_q <= 4'h0;
      o_sda_oe <= 1'b0;
      if (st_q == S_DEV) st_q <= rw_q ? S_RD : S_REG;
      else if (st_q == S_REG) st_q <= S_WR;
      else if (st_q == S_RD && nack_q) st_q <= S_IDLE;
    end else if (fall && st_q == S_RD && cnt_q != 4'h0) begin
      o_sda_oe <= ~sh_q[7];
    end
  end

  // Pointer survives a stop so a later read starts where the write left it
  always_ff @(posedge i_mclk) begin
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    stop_q <= stop & ~i_rst;
    if (i_rst) begin
      ptr_q <= 8'h00;
      addr_q <= 8'h00;
      wd_q <= 8'h00;
    end else if (fall && act && cnt_q == 4'h8 && st_q == S_REG) begin
      ptr_q <= sh_q;
    end else if (fall && act && cnt_q == 4'h8 && st_q == S_WR) begin
      wr_q <= 1'b1;
      addr_q <= ptr_q;
      wd_q <= sh_q;
      ptr_q <= ptr_q + 8'h01;
    end else if (fall && act && cnt_q == 4'h9 && ((st_q == S_DEV && rw_q) || (st_q == S_RD && !nack_q))) begin
      rd_q <= 1'b1;
      addr_q <= ptr_q;
      ptr_q <= ptr_q + 8'h01;
    end
  end

  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign bus.stop = stop_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wd_q;
endmodule : i2c_target
`default_nettype wire

// ---- hdl/power_mux_control_registers.sv ----
// Control and status logic of a two-to-one power multiplexer.
// Analog comparators arrive as asynchronous levels; registers via two-wire bus.
//
// Functional notes
// - Disable bit set turns both channels off, but dead battery keeps the high path on and an active swap the 5 V path; else select bit picks one.
// - High-rail overcurrent, overvoltage or thermal flag sets the disable bit.
// - High-rail current limit field, bits 6-5, reset 10.
// - Five-volt current limit field, bits 4-3, reset 11.
// - Direction bit 2: 1 sources charger rail to bus, 0 sinks.
// - Select bit 1: 1 high-voltage path, 0 five-volt path, reset 1.
// - Overcurrent delay field 1, 10, 50 or 100 ms, reset 01.
// - Discharge duration field 50 to 400 ms, reset 10.
// - Discharge resistance field selects resistor, reset 00.
// - Automatic discharge bit; when 0 discharge follows forced bit.
// - Busy during transition or discharge timing; writes to registers 1 to 3 ignored then.
// - Three-bit overvoltage threshold code selects one of eight profiles.
// - Reverse-block mask keeps alert quiet on reverse blocking.
// - Writing 1 to soft reset restores registers 1 to 4 but not the flags; 0 does nothing.
// - Bypass bits join controller and connector CC; host removes pull-down.
// - Cable-power select connects battery and forces matching bypass to 0.
// - Battery overvoltage flag alerts, clears on read once condition gone.
// - Cable overcurrent drops select bit, sets flag, alerts; read clears.
// - Swap detect bit 0 enables CC role swap detection, 1 disables.
// - CC low over 30 us stops sinking; bus drop then turns on 5 V path.
// - Detection off: sinking and bus drop swaps to 5 V path.
// - Swap flag and alert stay until host reads the flag.
// - Transistors need supply and enable pin; dead battery forces high path.
// - While busy, writes to registers 1 to 3 refused, register 4 accepted.
// - Open-drain alert stays low until flags are read.
`timescale 1ns/1ns
`default_nettype none
module power_mux_control_registers #(
  parameter int unsigned OC_UNIT_CYC  = pwr_mux_pkg::OC_UNIT_MS * 1000 * pwr_mux_pkg::CLK_MHZ,
  parameter int unsigned DSG_UNIT_CYC = pwr_mux_pkg::DSG_UNIT_MS * 1000 * pwr_mux_pkg::CLK_MHZ
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  input  wire logic [1:0] i_addr_sel,
  input  wire logic       i_en_pin,
  input  wire logic       i_supply_ok,
  input  wire logic       i_dead_battery,
  input  wire logic       i_hv_overcurrent,
  input  wire logic       i_overvoltage,
  input  wire logic       i_overtemp,
  input  wire logic       i_reverse_block,
  input  wire logic       i_vbat_over,
  input  wire logic       i_cable1_overcurrent,
  input  wire logic       i_cable2_overcurrent,
  input  wire logic       i_cc1_low,
  input  wire logic       i_cc2_low,
  input  wire logic       i_bus_below_low_rail,
  output logic            o_hv_on,
  output logic            o_lv_on,
  output logic            o_hv_source,
  output logic [1:0]      o_high_rail_current_limit,
  output logic [1:0]      o_lv_ilim,
  output logic [2:0]      o_ovp_code,
  output logic            o_dsg_on,
  output logic [1:0]      o_dsg_res,
  output logic            o_cc1_bypass,
  output logic            o_cc2_bypass,
  output logic            o_cable1_on,
  output logic            o_cable2_on,
  output logic            o_alert_oe
);
  localparam int NS = 15;
  logic [NS-1:0] raw, meta_q, sync_q;
  logic [1:0]  addr_s;
  logic        en_s, sup_s, dead_s, hvoc_s, ovp_s, tsd_s, rvs_s;
  logic        vbov_s, c1oc_s, c2oc_s, cc1l_s, cc2l_s, busl_s;
  logic [7:0]  p1_q, p2_q, p3_q, p4_q;
  logic        hvoc_f, rvs_f, ovp_f, tsd_f, frs_f, vbov_f, cboc_f;
  logic [31:0] oc_cnt_q, dsg_cnt_q, trans_cnt_q, deg_cnt_q;
  logic [31:0] oc_lim, dsg_lim;
  logic        busy, wr1, wr2, wr3, wr4, rd0, rd4;
  logic        srst_pend_q, srst_go;
  logic        gate, hv_on_d, lv_on_d, shut, src, oc_evt, trip;
  logic        frs_stop_q, frs_act_q, det_en, cc_low, hv_sink, frs_set;
  regbus_if    bus ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  // Read-clear flag: a new set wins over the read that clears it
  function automatic logic sticky(input logic set, input logic q, input logic rd, input logic cond);
    return set | (q & ~(rd & ~cond));
  endfunction : sticky

  function automatic int unsigned oc_mult(input logic [1:0] f);
    unique case (f)
      2'h0: return pwr_mux_pkg::OC_MULT0;
      2'h1: return pwr_mux_pkg::OC_MULT1;
      2'h2: return pwr_mux_pkg::OC_MULT2;
      2'h3: return pwr_mux_pkg::OC_MULT3;
    endcase
  endfunction : oc_mult

  i2c_target u_i2c (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_addr_sel (addr_s),
    .o_sda_oe   (o_sda_oe),
    .bus        (bus)
  );
  assign o_sda_out = 1'b0;

  assign raw = {i_addr_sel, i_en_pin, i_supply_ok, i_dead_battery, i_hv_overcurrent,
                i_overvoltage, i_overtemp, i_reverse_block, i_vbat_over, i_cable1_overcurrent,
                i_cable2_overcurrent, i_cc1_low, i_cc2_low, i_bus_below_low_rail};
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end
  assign {addr_s, en_s, sup_s, dead_s, hvoc_s, ovp_s, tsd_s, rvs_s, vbov_s,
          c1oc_s, c2oc_s, cc1l_s, cc2l_s, busl_s} = sync_q;

  // Register access
  assign busy = (trans_cnt_q != 32'h0) || (dsg_cnt_q != 32'h0);
  assign wr1 = bus.wr & hit(bus.addr, pwr_mux_pkg::REG_PATH) & ~busy;
  assign wr2 = bus.wr & hit(bus.addr, pwr_mux_pkg::REG_PROT) & ~busy;
  assign wr3 = bus.wr & hit(bus.addr, pwr_mux_pkg::REG_THR) & ~busy;
  assign wr4 = bus.wr & hit(bus.addr, pwr_mux_pkg::REG_CC);
  assign rd0 = bus.rd & hit(bus.addr, pwr_mux_pkg::REG_STATUS);
  assign rd4 = bus.rd & hit(bus.addr, pwr_mux_pkg::REG_CC);

  always_comb begin
    bus.rdata = 8'h00;
    if (hit(bus.addr, pwr_mux_pkg::REG_STATUS)) begin
      bus.rdata = {hvoc_f, rvs_f, 1'b0, ovp_f, frs_f, tsd_f, 2'h0};
    end else if (hit(bus.addr, pwr_mux_pkg::REG_PATH)) begin
      bus.rdata = p1_q;
    end else if (hit(bus.addr, pwr_mux_pkg::REG_PROT)) begin
      bus.rdata = p2_q;
    end else if (hit(bus.addr, pwr_mux_pkg::REG_THR)) begin
      bus.rdata = {busy, p3_q[6:1], 1'b0};
    end else if (hit(bus.addr, pwr_mux_pkg::REG_CC)) begin
      bus.rdata = {p4_q[7:4], vbov_f, cboc_f, p4_q[1:0]};
    end
  end

  // Soft reset waits for the stop so the acknowledge cycle finishes first
  always_ff @(posedge i_mclk) begin
    if (i_rst || bus.stop) srst_pend_q <= 1'b0;
    else if (wr3 && bus.wdata[pwr_mux_pkg::SRST_BIT]) srst_pend_q <= 1'b1;
  end
  assign srst_go = srst_pend_q & bus.stop;

  assign trip = (oc_evt & ~hvoc_f) | (ovp_s & ~ovp_f) | (tsd_s & ~tsd_f);
  always_ff @(posedge i_mclk) begin
    if (i_rst || srst_go) p1_q <= pwr_mux_pkg::PATH_RST;
    else if (wr1) p1_q <= bus.wdata;
    if (!i_rst && trip) p1_q[pwr_mux_pkg::PDIS_BIT] <= 1'b1;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || srst_go) p2_q <= pwr_mux_pkg::PROT_RST;
    else if (wr2) p2_q <= bus.wdata;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || srst_go) p3_q <= pwr_mux_pkg::THR_RST;
    else if (wr3) p3_q <= {1'b0, bus.wdata[6:1], 1'b0};
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || srst_go) begin
      p4_q <= pwr_mux_pkg::CC_RST;
    end else begin
      if (wr4) begin
        p4_q <= {bus.wdata[7] & ~bus.wdata[5], bus.wdata[6] & ~bus.wdata[4],
                 bus.wdata[5:4], 2'h0, bus.wdata[1:0]};
      end
      if (c1oc_s) p4_q[pwr_mux_pkg::CAB1_BIT] <= 1'b0;
      if (c2oc_s) p4_q[pwr_mux_pkg::CAB2_BIT] <= 1'b0;
    end
  end

  // Fault flags
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      {hvoc_f, rvs_f, ovp_f, tsd_f, frs_f, vbov_f, cboc_f} <= 7'h00;
    end else begin
      hvoc_f <= sticky(oc_evt, hvoc_f, rd0, hvoc_s);
      rvs_f <= sticky(rvs_s, rvs_f, rd0, rvs_s);
      ovp_f <= sticky(ovp_s, ovp_f, rd0, ovp_s);
      tsd_f <= sticky(tsd_s, tsd_f, rd0, tsd_s);
      frs_f <= sticky(frs_set & ~frs_act_q, frs_f, rd0, 1'b0);
      vbov_f <= sticky(vbov_s, vbov_f, rd4, vbov_s);
      cboc_f <= sticky(c1oc_s | c2oc_s, cboc_f, rd4, c1oc_s | c2oc_s);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) o_alert_oe <= 1'b0;
    else o_alert_oe <= hvoc_f | ovp_f | tsd_f | frs_f | vbov_f | cboc_f
                       | (rvs_f & ~p3_q[pwr_mux_pkg::MASK_BIT]);
  end

  // High-rail overcurrent must persist for the programmed delay
  assign oc_lim = 32'(OC_UNIT_CYC * oc_mult(p2_q[7:6]));
  always_ff @(posedge i_mclk) begin
    if (i_rst || !hvoc_s || !o_hv_on) oc_cnt_q <= 32'h0;
    else if (oc_cnt_q != oc_lim) oc_cnt_q <= oc_cnt_q + 32'h1;
  end
  assign oc_evt = hvoc_s && (oc_cnt_q == oc_lim);

  // Channel enables
  assign gate = sup_s & en_s;
  assign hv_on_d = dead_s | (gate & ~p1_q[pwr_mux_pkg::PDIS_BIT]
                   & p1_q[pwr_mux_pkg::SEL_BIT] & ~frs_stop_q & ~frs_act_q);
  assign lv_on_d = gate & ((~p1_q[pwr_mux_pkg::PDIS_BIT] & ~p1_q[pwr_mux_pkg::SEL_BIT])
                   | frs_act_q);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_hv_on <= 1'b0;
      o_lv_on <= 1'b0;
    end else begin
      o_hv_on <= hv_on_d;
      o_lv_on <= lv_on_d & ~hv_on_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) trans_cnt_q <= 32'h0;
    else if ({hv_on_d, lv_on_d & ~hv_on_d} != {o_hv_on, o_lv_on}) trans_cnt_q <= 32'(pwr_mux_pkg::TRANSITION_CYC);
    else if (trans_cnt_q != 32'h0) trans_cnt_q <= trans_cnt_q - 32'h1;
  end

  // Automatic discharge after a channel shuts down while sourcing
  assign dsg_lim = 32'(DSG_UNIT_CYC) << p2_q[5:4];
  assign shut = (o_hv_on & ~hv_on_d) | (o_lv_on & ~lv_on_d);
  assign src = p1_q[pwr_mux_pkg::DIR_BIT] | ~p1_q[pwr_mux_pkg::SEL_BIT];
  always_ff @(posedge i_mclk) begin
    if (i_rst || !p2_q[pwr_mux_pkg::AUTO_BIT]) dsg_cnt_q <= 32'h0;
    else if (shut && src) dsg_cnt_q <= dsg_lim;
    else if (dsg_cnt_q != 32'h0) dsg_cnt_q <= dsg_cnt_q - 32'h1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_dsg_on <= 1'b0;
    else if (p2_q[pwr_mux_pkg::AUTO_BIT]) o_dsg_on <= dsg_cnt_q != 32'h0;
    else o_dsg_on <= p2_q[pwr_mux_pkg::FORCE_BIT];
  end

  // Fast role swap
  assign det_en = ~p4_q[pwr_mux_pkg::SWDIS_BIT];
  assign hv_sink = o_hv_on & ~p1_q[pwr_mux_pkg::DIR_BIT];
  assign cc_low = (o_cc1_bypass & cc1l_s) | (o_cc2_bypass & cc2l_s);
  always_ff @(posedge i_mclk) begin
    if (i_rst || !(det_en && cc_low && hv_sink)) deg_cnt_q <= 32'h0;
    else if (deg_cnt_q != 32'(pwr_mux_pkg::CC_DEGLITCH_CYC)) deg_cnt_q <= deg_cnt_q + 32'h1;
  end
  assign frs_set = busl_s & (frs_stop_q | (~det_en & hv_sink));
  always_ff @(posedge i_mclk) begin
    if (i_rst || srst_go || wr1) frs_stop_q <= 1'b0;
    else if (deg_cnt_q == 32'(pwr_mux_pkg::CC_DEGLITCH_CYC)) frs_stop_q <= 1'b1;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) frs_act_q <= 1'b0;
    else if (frs_set) frs_act_q <= 1'b1;
    else if (srst_go || wr1) frs_act_q <= 1'b0;
  end

  // Static configuration straight from the registers
  assign o_high_rail_current_limit = p1_q[6:5];
  assign o_lv_ilim = p1_q[4:3];
  assign o_hv_source = p1_q[pwr_mux_pkg::DIR_BIT];
  assign o_dsg_res = p2_q[3:2];
  assign o_ovp_code = p3_q[6:4];
  assign o_cc1_bypass = p4_q[pwr_mux_pkg::BYP1_BIT];
  assign o_cc2_bypass = p4_q[pwr_mux_pkg::BYP2_BIT];
  // Battery overvoltage also opens the cable switches
  assign o_cable1_on = p4_q[pwr_mux_pkg::CAB1_BIT] & ~vbov_s;
  assign o_cable2_on = p4_q[pwr_mux_pkg::CAB2_BIT] & ~vbov_s;

  a_disable_off: assert property (@(posedge i_mclk) disable iff (i_rst)
    p1_q[7] && !dead_s && !frs_act_q |=> !o_hv_on && !o_lv_on)
    else $error("channel on while disabled");
  a_fault_disable: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(ovp_f) || $rose(tsd_f) || $rose(hvoc_f) |-> p1_q[7])
    else $error("fault left power enabled");
  a_busy_refuse: assert property (@(posedge i_mclk) disable iff (i_rst)
    busy && bus.wr && bus.addr == 8'h01 && !srst_go && !trip |=> $stable(p1_q))
    else $error("write taken while busy");
  a_cable_nobyp: assert property (@(posedge i_mclk) disable iff (i_rst)
    p4_q[5] |-> !o_cc1_bypass)
    else $error("bypass with cable power");
  a_swap_alert: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(frs_f) |=> o_alert_oe [*2])
    else $error("swap alert not held");
  a_deglitch_len: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(frs_stop_q) |-> $past(deg_cnt_q) == 32'd3751)
    else $error("swap deglitch length wrong");
  a_swap_lv: assert property (@(posedge i_mclk) disable iff (i_rst)
    frs_set && gate && !dead_s ##1 gate && !dead_s |=> o_lv_on && !o_hv_on)
    else $error("swap did not move to low rail");
  a_manual_dsg: assert property (@(posedge i_mclk) disable iff (i_rst)
    !p2_q[1] |=> o_dsg_on == $past(p2_q[0]))
    else $error("forced discharge not followed");
  a_soft_reset: assert property (@(posedge i_mclk) disable iff (i_rst)
    srst_go |=> p2_q == 8'h62 && p3_q == 8'h00)
    else $error("soft reset values wrong");
  // Fault, alert, enable and swap-detect paths the host sees directly
  a_cable_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    c1oc_s |=> !p4_q[5])
    else $error("cable select kept");
  a_cable_alert: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(cboc_f) |=> o_alert_oe)
    else $error("cable fault silent");
  a_vbat_alert: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(vbov_f) |=> o_alert_oe)
    else $error("battery fault silent");
  a_vbat_cut: assert property (@(posedge i_mclk) disable iff (i_rst)
    vbov_s |-> !o_cable1_on && !o_cable2_on)
    else $error("cable on at battery fault");
  a_mask_alert: assert property (@(posedge i_mclk) disable iff (i_rst)
    rvs_f && !p3_q[3] |=> o_alert_oe)
    else $error("reverse block silent");
  a_enable_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
    !gate && !dead_s |=> !o_hv_on && !o_lv_on)
    else $error("channel on without enable");
  a_dead_force: assert property (@(posedge i_mclk) disable iff (i_rst)
    dead_s |=> o_hv_on)
    else $error("dead battery path off");
  a_swap_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    rd0 && !frs_set |=> !frs_f)
    else $error("swap flag kept after read");
  a_detect_off: assert property (@(posedge i_mclk) disable iff (i_rst)
    !det_en |=> deg_cnt_q == 32'h0)
    else $error("swap detect while disabled");
endmodule : power_mux_control_registers
`default_nettype wire

// ---- sim/i2c_host_model.sv ----
// Two-wire bus host model: START, STOP and nine-bit slots.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tk
  // SDA moves while SCL is high only here, framing START or STOP
  task automatic cond(input logic st);
    o_sda_low = ~st;
    tk(11);
    o_scl = 1'b1;
    tk(11);
    o_sda_low = st;
    tk(11);
    if (st) begin
      o_scl = 1'b0;
      tk(4);
    end
  endtask : cond
  // Data changes well after SCL falls, clear of the target's synchronisers
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = ~d[i];
      tk(7);
      o_scl = 1'b1;
      tk(11);
      q[i] = i_sda;
      o_scl = 1'b0;
      tk(4);
    end
  endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// ---- sim/power_mux_control_registers_bench.sv ----
// Bench for the power multiplexer control block with a register model.
// Assumes the host model drives the serial pins; SDA is open drain.
`timescale 1ns/1ns
`default_nettype none
module power_mux_control_registers_bench;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_scl, sda_low, busy_exp, i_en_pin, i_supply_ok, i_dead_battery;
  logic i_hv_overcurrent, i_overvoltage, i_overtemp, i_reverse_block, i_vbat_over, i_cc1_low, i_cc2_low;
  logic i_cable1_overcurrent, i_cable2_overcurrent, i_bus_below_low_rail, o_sda_out, o_sda_oe;
  logic o_hv_on, o_lv_on, o_hv_source, o_dsg_on, o_cc1_bypass, o_cc2_bypass, o_cable1_on, o_cable2_on;
  logic o_alert_oe;
  logic [1:0] i_addr_sel, o_high_rail_current_limit, o_lv_ilim, o_dsg_res;
  logic [2:0] o_ovp_code;
  logic [7:0] d;
  logic [7:0] m [1:4];
  logic [7:0] fl [3] = '{8'h80, 8'h10, 8'h04};
  int seed = 73747, n_checks = 0, miscompares = 0;
  wire logic i_sda = ~(sda_low | o_sda_oe);
  wire logic [6:0] dev = {pwr_mux_pkg::DEV_ADDR_BASE, i_addr_sel};
  wire logic [7:0] outs = {o_cc1_bypass, o_cc2_bypass, o_cable1_on, o_cable2_on, o_alert_oe, o_hv_on, o_lv_on,
                           o_sda_out};
  always #4 i_mclk = ~i_mclk;
  i2c_host_model i2c_host_model_inst (.i_mclk, .i_sda, .o_scl(i_scl), .o_sda_low(sda_low));
  power_mux_control_registers #(.OC_UNIT_CYC(10), .DSG_UNIT_CYC(20)) power_mux_control_registers_inst (
    .i_mclk, .i_rst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_addr_sel, .i_en_pin, .i_supply_ok,
    .i_dead_battery, .i_hv_overcurrent, .i_overvoltage, .i_overtemp, .i_reverse_block, .i_vbat_over,
    .i_cable1_overcurrent, .i_cable2_overcurrent, .i_cc1_low, .i_cc2_low, .i_bus_below_low_rail,
    .o_hv_on, .o_lv_on, .o_hv_source, .o_high_rail_current_limit, .o_lv_ilim, .o_ovp_code, .o_dsg_on, .o_dsg_res,
    .o_cc1_bypass, .o_cc2_bypass, .o_cable1_on, .o_cable2_on, .o_alert_oe);
  task automatic tk(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tk
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic mreset;
    m = '{pwr_mux_pkg::PATH_RST, pwr_mux_pkg::PROT_RST, pwr_mux_pkg::THR_RST, pwr_mux_pkg::CC_RST};
  endtask : mreset
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    logic [8:0] q;
    i2c_host_model_inst.cond(1'b1);
    i2c_host_model_inst.xfer({dev, 2'b01}, q);
    i2c_host_model_inst.xfer({r, 1'b1}, q);
    i2c_host_model_inst.xfer({v, 1'b1}, q);
    i2c_host_model_inst.cond(1'b0);
    if (r == 8'h04)
      m[4] = {v[7] & ~v[5], v[6] & ~v[4], v[5:4], 2'h0, v[1:0]};
    else if (!busy_exp && r == 8'h03 && v[0])
      mreset();
    else if (!busy_exp && r inside {8'h01, 8'h02, 8'h03})
      m[r] = v;
  endtask : wr
  task automatic rd(input logic [7:0] r, input logic [7:0] e, input string nm);
    logic [8:0] q;
    i2c_host_model_inst.cond(1'b1);
    i2c_host_model_inst.xfer({dev, 2'b01}, q);
    i2c_host_model_inst.xfer({r, 1'b1}, q);
    i2c_host_model_inst.cond(1'b0);
    i2c_host_model_inst.cond(1'b1);
    i2c_host_model_inst.xfer({dev, 2'b11}, q);
    i2c_host_model_inst.xfer(9'h1FF, q);
    i2c_host_model_inst.cond(1'b0);
    chk(nm, q[8:1], e);
  endtask : rd
  task automatic rdm(input logic [7:0] r);
    rd(r, r == 8'h03 ? {busy_exp, m[3][6:0]} : m[r], "register");
  endtask : rdm
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  initial begin
    {i_en_pin, i_supply_ok, i_dead_battery, i_hv_overcurrent, i_overvoltage, i_overtemp} = '0;
    {i_reverse_block, i_vbat_over, i_cable1_overcurrent, i_cable2_overcurrent, busy_exp} = '0;
    {i_cc1_low, i_cc2_low, i_bus_below_low_rail} = '0;
    i_addr_sel = 2'($random(seed));
    mreset();
    repeat (16) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    tk(4);
    for (int r = 1; r <= 4; r++)
      rdm(8'(r));
    // Enable pin low keeps every random setting away from channel transitions
    repeat (3) begin
      d = 8'($random(seed));
      wr(8'h01, d);
      wr(8'h02, d & 8'hFD);
      wr(8'h03, d & 8'hFE);
      for (int r = 1; r <= 3; r++)
        rdm(8'(r));
      chk("fields", {o_high_rail_current_limit, o_lv_ilim, o_hv_source, o_dsg_res, o_dsg_on}, {d[6:2], d[3:2], d[0]});
      chk("misc", {o_ovp_code, o_hv_on, o_lv_on, 3'h0}, {d[6:4], 5'h0});
    end
    wr(8'h04, 8'hC2);
    chk("outs", outs, 8'hC0);
    wr(8'h04, 8'hF0);
    chk("outs", outs, 8'h30);
    i_cable1_overcurrent = 1'b1;
    tk(20);
    chk("outs", outs, 8'h18);
    i_cable1_overcurrent = 1'b0;
    m[4] = 8'h10;
    rd(8'h04, 8'h14, "flags");
    rdm(8'h04);
    chk("outs", outs, 8'h10);
    i_vbat_over = 1'b1;
    tk(20);
    chk("outs", outs, 8'h08);
    rd(8'h04, 8'h18, "flags");
    i_vbat_over = 1'b0;
    rd(8'h04, 8'h18, "flags");
    rdm(8'h04);
    for (int k = 1; k < 3; k++) begin
      {i_hv_overcurrent, i_overvoltage, i_overtemp} = 3'b100 >> k;
      tk(1100);
      chk("outs", outs, 8'h18);
      {i_hv_overcurrent, i_overvoltage, i_overtemp} = 3'b000;
      rd(8'h00, fl[k], "status");
      m[1][7] = 1'b1;
      rdm(8'h01);
      chk("outs", outs, 8'h10);
      m[1][7] = 1'b0;
      wr(8'h01, m[1]);
    end
    wr(8'h03, 8'h08);
    i_reverse_block = 1'b1;
    tk(20);
    chk("outs", outs, 8'h10);
    i_reverse_block = 1'b0;
    wr(8'h03, 8'h00);
    i_reverse_block = 1'b1;
    tk(20);
    chk("outs", outs, 8'h18);
    i_reverse_block = 1'b0;
    rd(8'h00, 8'h40, "status");
    wr(8'h03, 8'h01);
    for (int r = 1; r <= 4; r++)
      rdm(8'(r));
    {i_en_pin, i_supply_ok, busy_exp} = 3'b111;
    wr(8'h01, 8'h80);
    wr(8'h04, 8'hC0);
    rdm(8'h03);
    tk(1000);
    busy_exp = 1'b0;
    rdm(8'h01);
    chk("outs", outs, 8'hC4);
    i_en_pin = 1'b0;
    tk(10);
    chk("outs", outs, 8'hC0);
    i_dead_battery = 1'b1;
    tk(10);
    chk("outs", outs, 8'hC4);
    {i_dead_battery, i_en_pin, i_hv_overcurrent} = 3'b011;
    tk(120);
    chk("outs", outs, 8'hC8);
    i_hv_overcurrent = 1'b0;
    rd(8'h00, fl[0], "status");
    m[1][7] = 1'b1;
    rdm(8'h01);
    chk("outs", outs, 8'hC0);
    tk(700);
    wr(8'h01, 8'h5A);
    chk("outs", outs, 8'hC4);
    {i_cc1_low, i_cc2_low} = 2'b01 << d[0];
    tk(3800);
    chk("outs", outs, 8'hC0);
    i_bus_below_low_rail = 1'b1;
    tk(10);
    chk("outs", outs, 8'hCA);
    {i_bus_below_low_rail, i_cc1_low, i_cc2_low} = 3'h0;
    rd(8'h00, 8'h08, "status");
    chk("outs", outs, 8'hC2);
    wrap_up();
  end
endmodule : power_mux_control_registers_bench
`default_nettype wire
